// >>> logic/dacr_top.sv
// Reference generator and dual converter control with an APB register slave.
// Assumes a 50 MHz I_REF_CLK, APB master on the same clock, and an
// amplifier flag that arrives asynchronously on a pin.
//
// Notes on behaviour
// - A one in the reference enable bit powers the internal reference.
// - A zero in the reference enable bit powers it down, output floating.
// - Reference select 00/01 picks internal, 10 regulated, 11 floating.
// - Unimplemented bits ignore writes and read as zero.
// - Trim is nominal at 80h, each step lowers the reference about 500uV.
// - Trim spans about -60mV to +60mV around nominal.
// - Mode 00 off high-Z, 01/11 on, 10 off grounded.
// - The code is 12 bits: high byte bits 11..4, low bits 7..4 bits 3..0.
// - Two independent channels with own mode and data registers.
// - Bit 7 of each pin switch register joins converter 1 to that pin.
// - Bit 6 of each pin switch register joins converter 2 to that pin.
// - Bit 7 of reference control reads the amplifier 1 flag, reset zero.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module dacr_top (
  input  wire logic        I_REF_CLK,        // 50 MHz clock
  input  wire logic        I_RESETN,         // Async reset, low
  input  wire logic        I_CE,             // Clock enable
  input  wire logic        I_PSEL,           // APB select
  input  wire logic        I_PENABLE,        // APB enable
  input  wire logic        I_PWRITE,         // APB direction
  input  wire logic [7:0]  I_PADDR,          // APB byte address
  input  wire logic [31:0] I_PWDATA,         // APB write data
  output logic [31:0]      O_PRDATA,         // APB read data
  output logic             O_PREADY,         // APB ready
  output logic             O_PSLVERR,        // APB error
  input  wire logic        I_AMP1_FLAG,      // Amplifier 1 output pin
  output logic             O_REF_POWER,      // Reference generator on
  output logic [1:0]       O_CONV_REF_SRC,   // Converter reference source
  output logic [7:0]       O_REF_TRIM,       // Reference trim code
  output logic             O_CONV1_ON,       // Converter 1 enabled
  output logic             O_CONV1_GND,      // Converter 1 output grounded
  output logic [11:0]      O_CONV1_CODE,     // Converter 1 code
  output logic             O_CONV2_ON,       // Converter 2 enabled
  output logic             O_CONV2_GND,      // Converter 2 output grounded
  output logic [11:0]      O_CONV2_CODE,     // Converter 2 code
  output logic [7:0]       O_PIN_CONV1_SW,   // Converter 1 to pin switches
  output logic [7:0]       O_PIN_CONV2_SW    // Converter 2 to pin switches
);

  // ==========================================================
  // Decode helpers
  function automatic logic is_pin(input logic [7:0] a);
    is_pin = (a >= dacr_pkg::OFS_PIN_BASE) && (a <= dacr_pkg::OFS_PIN_LAST)
             && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] pin_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - dacr_pkg::OFS_PIN_BASE;
    pin_index = d[4:2];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = is_pin(a) || (a[1:0] == 2'b00 && a <= dacr_pkg::OFS_C2_HIGH);
  endfunction

  // ==========================================================
  // State
  logic        ref_en, next_ref_en;
  logic [1:0]  ref_sel, next_ref_sel;
  logic [7:0]  trim, next_trim;
  logic [7:0]  sw1, next_sw1;
  logic [7:0]  sw2, next_sw2;
  logic [31:0] rdata, next_rdata;
  logic        amp1_flag;

  logic        wr_en, rd_setup;
  logic [7:0]  wbyte;
  logic [2:0]  pidx;

  dacr_chan_if ch1 ();
  dacr_chan_if ch2 ();

  // ==========================================================
  // Submodules
  // synchronised flag
  dacr_sync u_amp1_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESETN),
    .i_ce    (I_CE),
    .i_async (I_AMP1_FLAG),
    .o_level (amp1_flag)
  );

  dacr_channel u_chan1 (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESETN),
    .i_ce    (I_CE),
    .bus     (ch1.chan)
  );

  dacr_channel u_chan2 (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RESETN),
    .i_ce    (I_CE),
    .bus     (ch2.chan)
  );

  // ==========================================================
  // APB strobes
  // Zero wait states; a frozen clock enable holds the access.
  assign O_PREADY  = I_CE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped(I_PADDR);
  assign wr_en     = I_CE & I_PSEL & I_PENABLE & I_PWRITE & mapped(I_PADDR);
  assign rd_setup  = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign wbyte     = I_PWDATA[7:0];
  assign pidx      = pin_index(I_PADDR);

  assign ch1.wdata   = wbyte;
  assign ch2.wdata   = wbyte;
  assign ch1.wr_mode = wr_en & (I_PADDR == dacr_pkg::OFS_C1_MODE);
  assign ch2.wr_mode = wr_en & (I_PADDR == dacr_pkg::OFS_C2_MODE);
  assign ch1.wr_low  = wr_en & (I_PADDR == dacr_pkg::OFS_C1_LOW);
  assign ch2.wr_low  = wr_en & (I_PADDR == dacr_pkg::OFS_C2_LOW);
  assign ch1.wr_high = wr_en & (I_PADDR == dacr_pkg::OFS_C1_HIGH);
  assign ch2.wr_high = wr_en & (I_PADDR == dacr_pkg::OFS_C2_HIGH);

  // ==========================================================
  // Local registers, next values
  always_comb begin
    next_ref_en  = ref_en;
    next_ref_sel = ref_sel;
    next_trim    = trim;
    next_sw1     = sw1;
    next_sw2     = sw2;
    if (wr_en) begin
      if (I_PADDR == dacr_pkg::OFS_REF_CTRL) begin
        next_ref_en  = wbyte[dacr_pkg::POS_REF_EN];
        next_ref_sel = wbyte[dacr_pkg::POS_REF_SEL +: 2];
      end
      if (I_PADDR == dacr_pkg::OFS_REF_TRIM) begin
        next_trim = wbyte;
      end
      if (is_pin(I_PADDR)) begin
        next_sw1[pidx] = wbyte[dacr_pkg::POS_PIN_CONV1];
        next_sw2[pidx] = wbyte[dacr_pkg::POS_PIN_CONV2];
      end
    end
  end

  // ==========================================================
  // Read data, latched in the setup phase
  always_comb begin
    next_rdata = rdata;
    if (rd_setup) begin
      next_rdata = 32'h0000_0000;
      unique case (I_PADDR)
        dacr_pkg::OFS_REF_CTRL: begin
          next_rdata[dacr_pkg::POS_AMP1_FLAG]      = amp1_flag;
          next_rdata[dacr_pkg::POS_REF_EN]         = ref_en;
          next_rdata[dacr_pkg::POS_REF_SEL +: 2]   = ref_sel;
        end
        dacr_pkg::OFS_REF_TRIM: next_rdata[7:0] = trim;
        dacr_pkg::OFS_C1_MODE:  next_rdata[1:0] = ch1.mode;
        dacr_pkg::OFS_C2_MODE:  next_rdata[1:0] = ch2.mode;
        dacr_pkg::OFS_C1_LOW:   next_rdata[dacr_pkg::POS_LOW_NIB +: 4] = ch1.low;
        dacr_pkg::OFS_C2_LOW:   next_rdata[dacr_pkg::POS_LOW_NIB +: 4] = ch2.low;
        dacr_pkg::OFS_C1_HIGH:  next_rdata[7:0] = ch1.high;
        dacr_pkg::OFS_C2_HIGH:  next_rdata[7:0] = ch2.high;
        default: begin
          if (is_pin(I_PADDR)) begin
            next_rdata[dacr_pkg::POS_PIN_CONV1] = sw1[pidx];
            next_rdata[dacr_pkg::POS_PIN_CONV2] = sw2[pidx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ref_en  <= 1'b0;
      ref_sel <= dacr_pkg::RST_REF_SEL;
      trim    <= dacr_pkg::RST_REF_TRIM;
      sw1     <= 8'h00;
      sw2     <= 8'h00;
      rdata   <= 32'h0000_0000;
    end else if (I_CE) begin
      ref_en  <= next_ref_en;
      ref_sel <= next_ref_sel;
      trim    <= next_trim;
      sw1     <= next_sw1;
      sw2     <= next_sw2;
      rdata   <= next_rdata;
    end
  end

  // ==========================================================
  // Analog controls
  // reference powered
  assign O_REF_POWER = ref_en;

  always_comb begin
    if (!ref_en || ref_sel == dacr_pkg::SEL_FLOAT) begin
      O_CONV_REF_SRC = dacr_pkg::DACR_SRC_FLOATING;
    end else if (ref_sel == dacr_pkg::SEL_REGULATED) begin
      O_CONV_REF_SRC = dacr_pkg::DACR_SRC_REGULATED;
    end else begin
      O_CONV_REF_SRC = dacr_pkg::DACR_SRC_INTERNAL;
    end
  end

  assign O_REF_TRIM = trim;

  assign O_CONV1_ON   = ch1.mode[0];
  assign O_CONV1_GND  = (ch1.mode == dacr_pkg::MODE_OFF_GND);
  assign O_CONV2_ON   = ch2.mode[0];
  assign O_CONV2_GND  = (ch2.mode == dacr_pkg::MODE_OFF_GND);
  assign O_CONV1_CODE = ch1.code;
  assign O_CONV2_CODE = ch2.code;

  assign O_PIN_CONV1_SW = sw1;
  assign O_PIN_CONV2_SW = sw2;
  assign O_PRDATA       = rdata;

endmodule

// >>> logic/dacr_pkg.sv
// Constants for the reference and converter control block.
// Assumes a 32-bit APB slave with one aligned word per register.
package dacr_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_REF_CTRL  = 8'h00;
  localparam logic [7:0] OFS_REF_TRIM  = 8'h04;
  localparam logic [7:0] OFS_C1_MODE   = 8'h08;
  localparam logic [7:0] OFS_C2_MODE   = 8'h0c;
  localparam logic [7:0] OFS_C1_LOW    = 8'h10;
  localparam logic [7:0] OFS_C2_LOW    = 8'h14;
  localparam logic [7:0] OFS_C1_HIGH   = 8'h18;
  localparam logic [7:0] OFS_C2_HIGH   = 8'h1c;
  localparam logic [7:0] OFS_PIN_BASE  = 8'h20;
  localparam logic [7:0] OFS_PIN_LAST  = 8'h3c;

  // ==========================================================
  // Field positions
  localparam int POS_AMP1_FLAG  = 7;
  localparam int POS_REF_EN     = 4;
  localparam int POS_REF_SEL    = 0;
  localparam int POS_LOW_NIB    = 4;
  localparam int POS_PIN_CONV1  = 7;
  localparam int POS_PIN_CONV2  = 6;
  localparam int NUM_PINS       = 8;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_REF_TRIM = 8'h00;
  localparam logic [1:0] RST_MODE     = 2'h0;
  localparam logic [3:0] RST_LOW      = 4'h0;
  localparam logic [7:0] RST_HIGH     = 8'h00;
  localparam logic [1:0] RST_REF_SEL  = 2'h0;

  // ==========================================================
  // Encodings
  localparam logic [1:0] MODE_OFF_HIZ = 2'h0;
  localparam logic [1:0] MODE_OFF_GND = 2'h2;
  localparam logic [1:0] SEL_REGULATED = 2'h2;
  localparam logic [1:0] SEL_FLOAT     = 2'h3;

  typedef enum logic [1:0] {
    DACR_SRC_INTERNAL  = 2'h0,
    DACR_SRC_REGULATED = 2'h1,
    DACR_SRC_FLOATING  = 2'h2
  } dacr_src_t;

endpackage

// >>> logic/dacr_chan_if.sv
// Link between the register slave and one converter channel.
// Assumes both ends share I_REF_CLK.
`timescale 1ns/1ps
interface dacr_chan_if;
  logic       wr_mode;
  logic       wr_low;
  logic       wr_high;
  logic [7:0] wdata;
  logic [1:0] mode;
  logic [3:0] low;
  logic [7:0] high;
  logic [11:0] code;

  modport ctrl (output wr_mode, wr_low, wr_high, wdata, input mode, low, high, code);
  modport chan (input wr_mode, wr_low, wr_high, wdata, output mode, low, high, code);
endinterface

// >>> logic/dacr_sync.sv
// Three-stage synchroniser for a pin level.
// Assumes the input is asynchronous to the clock.
`timescale 1ns/1ps
module dacr_sync (
  input  wire logic i_clk,    // Clock
  input  wire logic i_rst_n,  // Async reset, low
  input  wire logic i_ce,     // Clock enable
  input  wire logic i_async,  // Raw pin level
  output logic      o_level   // Filtered level
);

  logic s1, s2, s3, level;
  logic next_s1, next_s2, next_s3, next_level;

  always_comb begin
    next_s1    = i_async;
    next_s2    = s1;
    next_s3    = s2;
    next_level = (s2 == s3) ? s3 : level;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else if (i_ce) begin
      s1    <= next_s1;
      s2    <= next_s2;
      s3    <= next_s3;
      level <= next_level;
    end
  end

  assign o_level = level;

endmodule

// >>> logic/dacr_channel.sv
// One converter channel: mode, code low nibble and high byte, and the code
// handed to the converter.
// Assumes write strobes are single-cycle pulses from the register slave.
`timescale 1ns/1ps
module dacr_channel (
  input  wire logic  i_clk,    // Clock
  input  wire logic  i_rst_n,  // Async reset, low
  input  wire logic  i_ce,     // Clock enable
  dacr_chan_if.chan  bus       // Register side
);

  logic [1:0]  mode, next_mode;
  logic [3:0]  low, next_low;
  logic [7:0]  high, next_high;
  logic [11:0] code, next_code;

  always_comb begin
    next_mode = mode;
    next_low  = low;
    next_high = high;
    next_code = code;
    if (bus.wr_mode) begin
      next_mode = bus.wdata[1:0];
    end
    if (bus.wr_low) begin
      next_low = bus.wdata[dacr_pkg::POS_LOW_NIB +: 4];
    end
    if (bus.wr_high) begin
      next_high = bus.wdata;
      next_code = {bus.wdata, low};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= dacr_pkg::RST_MODE;
      low  <= dacr_pkg::RST_LOW;
      high <= dacr_pkg::RST_HIGH;
      code <= 12'h000;
    end else if (i_ce) begin
      mode <= next_mode;
      low  <= next_low;
      high <= next_high;
      code <= next_code;
    end
  end

  assign bus.mode = mode;
  assign bus.low  = low;
  assign bus.high = high;
  assign bus.code = code;

endmodule

// >>> verification/dacr_checker.sv
// Port assertions for the reference and converter control block.
// Assumes it is bound into dacr_top and sees its ports by name.
`timescale 1ns/1ps
module dacr_checker (
  input wire logic        I_REF_CLK,      // Clock
  input wire logic        I_RESETN,       // Reset, low
  input wire logic        I_CE,           // Enable
  input wire logic        I_PSEL,         // Select
  input wire logic        I_PENABLE,      // Access
  input wire logic        I_PWRITE,       // Write
  input wire logic [7:0]  I_PADDR,        // Address
  input wire logic [31:0] I_PWDATA,       // Wdata
  input wire logic [31:0] O_PRDATA,       // Rdata
  input wire logic        O_PSLVERR,      // Error
  input wire logic        O_REF_POWER,    // Ref on
  input wire logic [1:0]  O_CONV_REF_SRC, // Ref source
  input wire logic        O_CONV1_ON,     // Conv1 on
  input wire logic        O_CONV1_GND,    // Conv1 grounded
  input wire logic [11:0] O_CONV1_CODE,   // Conv1 code
  input wire logic [11:0] O_CONV2_CODE,   // Conv2 code
  input wire logic [7:0]  O_PIN_CONV1_SW, // Conv1 switches
  input wire logic [7:0]  O_PIN_CONV2_SW  // Conv2 switches
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);

  // ==========================================================
  // Register writes, reads and error responses
  sequence s_wr(logic [7:0] a);
    I_PSEL && I_PENABLE && I_PWRITE && I_CE && I_PADDR == a;
  endsequence

  AST_REF_EN: assert property (
    s_wr(8'h00) |=> O_REF_POWER == $past(I_PWDATA[4]))
    else $error("Reference enable not applied");
  AST_REF_OFF: assert property (
    !O_REF_POWER |-> O_CONV_REF_SRC == 2'h2)
    else $error("Reference not floating while off");
  AST_REF_SEL: assert property (
    s_wr(8'h00) ##0 I_PWDATA[4] |=> O_CONV_REF_SRC ==
    ($past(I_PWDATA[1]) ? ($past(I_PWDATA[0]) ? 2'h2 : 2'h1) : 2'h0))
    else $error("Reference source wrong");
  AST_MODE: assert property (
    s_wr(8'h08) |=> O_CONV1_ON == $past(I_PWDATA[0])
    && O_CONV1_GND == ($past(I_PWDATA[1:0]) == 2'h2))
    else $error("Converter mode wrong");
  AST_LOW_HOLD: assert property (
    s_wr(8'h10) |=> $stable(O_CONV1_CODE))
    else $error("Code moved on low write");
  AST_HIGH: assert property (
    s_wr(8'h18) |=> O_CONV1_CODE[11:4] == $past(I_PWDATA[7:0]))
    else $error("Code high byte wrong");
  AST_CH_SEP: assert property (
    s_wr(8'h18) |=> $stable(O_CONV2_CODE))
    else $error("Channel two disturbed");
  AST_PIN_SW: assert property (
    I_PSEL && I_PENABLE && I_PWRITE && I_CE && I_PADDR[7:5] == 3'h1
    && I_PADDR[1:0] == 2'h0 |=> {O_PIN_CONV1_SW[$past(I_PADDR[4:2])],
    O_PIN_CONV2_SW[$past(I_PADDR[4:2])]} == $past(I_PWDATA[7:6]))
    else $error("Pin switch wrong");
  AST_UNMAPPED: assert property (
    I_PSEL && I_PENABLE && I_PADDR > 8'h3c |-> O_PSLVERR)
    else $error("Unmapped access not flagged");
  AST_RD_HIGH: assert property (
    I_PSEL && I_PENABLE && !I_PWRITE |-> O_PRDATA[31:8] == 24'h0)
    else $error("Upper read bits not zero");
endmodule

bind dacr_top dacr_checker u_chk (.*);

// >>> verification/dacr_analog_model.sv
// Analog side: pin switches of both converters, checked for shorts.
// Assumes switch vectors straight from the block outputs.
`timescale 1ns/1ps
module dacr_analog_model (
  input  wire logic [7:0] i_sw1,   // Converter 1 switches
  input  wire logic [7:0] i_sw2,   // Converter 2 switches
  output logic            o_short  // Two sources on a pin
);
  // Both converters on one pin short their outputs
  assign o_short = |(i_sw1 & i_sw2);
endmodule

// >>> verification/dacr_top_tb.sv
// Self-checking bench for the reference and converter control block.
// Assumes dacr_top, the checker bind and the analog model.
`timescale 1ns/1ps
module dacr_top_tb;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, amp = 0, ce = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        err, rdy, slverr, ref_on, c1on, c1gnd, c2on, c2gnd, shorted;
  logic [1:0]  src;
  logic [7:0]  trim, sw1, sw2;
  logic [11:0] code1, code2;
  int          fails = 0, n_compared = 0;

  always #10 clk = ~clk;

  dacr_top DUT (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(rdy), .O_PSLVERR(slverr), .I_AMP1_FLAG(amp),
    .O_REF_POWER(ref_on), .O_CONV_REF_SRC(src), .O_REF_TRIM(trim),
    .O_CONV1_ON(c1on), .O_CONV1_GND(c1gnd), .O_CONV1_CODE(code1),
    .O_CONV2_ON(c2on), .O_CONV2_GND(c2gnd), .O_CONV2_CODE(code2),
    .O_PIN_CONV1_SW(sw1), .O_PIN_CONV2_SW(sw2));
  dacr_analog_model u_far (.i_sw1(sw1), .i_sw2(sw2), .o_short(shorted));

  // ==========================================================
  // Bus and compare
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prdata; err = slverr;
    psel <= 1'b0; pen <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_ref;
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 32'h10 | s);
      chk(src, (s == 2) ? 2'h1 : (s == 3) ? 2'h2 : 2'h0);
      chk(ref_on, 1'b1);
    end
    wr(8'h00, 32'hff);
    rchk(8'h00, 32'h13);
    wr(8'h00, 32'h02);
    chk({ref_on, src}, 3'h2);
  endtask
  task automatic t_amp;
    @(posedge clk);
    amp <= 1'b1;
    repeat (5) @(posedge clk);
    wr(8'h00, 32'h02);
    rchk(8'h00, 32'h82);
    @(posedge clk);
    amp <= 1'b0;
    repeat (5) @(posedge clk);
    rchk(8'h00, 32'h02);
  endtask
  task automatic t_trim;
    wr(8'h04, 32'h80);
    chk(trim, 8'h80);
    chk(err, 1'b0);
    wr(8'h04, 32'h7f);
    rchk(8'h04, 32'h7f);
  endtask
  task automatic t_ce;
    @(posedge clk);
    ce <= 1'b0;
    fork
      wr(8'h04, 32'h5a);
      begin
        repeat (4) @(posedge clk);
        chk({rdy, trim}, 9'h07f);
        ce <= 1'b1;
      end
    join
    chk(trim, 8'h5a);
  endtask
  task automatic t_mode;
    for (int m = 0; m < 8; m++) begin
      wr(m[2] ? 8'h0c : 8'h08, m[1:0]);
      chk(m[2] ? {c2on, c2gnd} : {c1on, c1gnd}, {m[0], m[1:0] == 2'h2});
    end
    wr(8'h08, 32'hfd);
    rchk(8'h08, 32'h01);
  endtask
  task automatic t_code;
    wr(8'h10, 32'hab);
    chk(code1, 12'h000);
    rchk(8'h10, 32'ha0);
    wr(8'h18, 32'hff);
    chk({code1, code2}, 24'hffa000);
    wr(8'h14, 32'h50);
    wr(8'h1c, 32'h00);
    chk({code1, code2}, 24'hffa005);
    wr(8'h10, 32'hf0);
    chk(code1, 12'hffa);
    wr(8'h18, 32'hff);
    chk(code1, 12'hfff);
  endtask
  task automatic t_pins;
    for (int i = 0; i < 8; i++) begin
      wr(8'h20 + 8'(4 * i), 32'h3f);
      rchk(8'h20 + 8'(4 * i), 32'h0);
      wr(8'h20 + 8'(4 * i), i[0] ? 32'h40 : 32'h80);
      chk({sw1[i], sw2[i]}, {~i[0], i[0]});
      chk(shorted, 1'b0);
    end
  endtask
  task automatic t_err;
    wr(8'h40, 32'hff);
    chk(err, 1'b1);
    rchk(8'h40, 32'h0);
  endtask
  task automatic t_rst;
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk({ref_on, trim, c1on, c1gnd, c2on, c2gnd, sw1, sw2}, 0);
    chk({code1, code2, src}, 26'h2);
    @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h18, 32'h0);
  endtask

  task automatic summarize;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h00, 32'h0);
    t_ref; t_amp; t_trim; t_ce; t_mode; t_code; t_pins; t_err; t_rst;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize;
  end
endmodule
